// ### rtl/rps_pkg.sv
// Shared constants, types and states of the reset, power and security controller
//////////////////////////////////////////////////////////////////////////////
// How it works
// RULE1: Run keeps core and peripheral clocks on
// RULE2: Wait gates core/memory; interrupt wakes core
// RULE3: Stop exits on CAN, interrupt, or resets
// RULE4: Peripherals use bus clock, at most 60MHz
// RULE5: Software shuts PLL before Stop itself
// RULE6: Control register disables Stop/Wait, lock till reset
// RULE7: Four reset sources, two async, two sync
// RULE8: Power-on reset extended two-to-the-21 clocks
// RULE9: Three 32-clock release windows, then code runs
// RULE10: Reset release synchronised to rising clock edge
// RULE11: Security taken from two flash bytes
// RULE12: Secured part disables core debug only; the code also drives mem_read_disable_out from security
// RULE13: Boot picks unsecured or secure mode
// RULE14: Chip TAP always active after boot
// RULE15: Security bytes drive memory read disable
// RULE16: Recovery selects 7-bit flash divider register
// RULE17: Divider replaces flash divide register during recovery
// RULE18: Host picks divider for 150-200kHz clock
// RULE19: Run-Test/Idle starts and holds the erase
// RULE20: Recovery mass-erases flash, clearing security
// RULE21: Host resets TAP and chip afterwards
// RULE22: Backdoor access only with key enable set
// RULE23: Program key, code, then security bytes
// RULE24: Integration clocks keep running in Stop
//////////////////////////////////////////////////////////////////////////////
package rps_pkg;

  localparam int CLK_HZ            = 50_000_000;
  localparam int PERIPH_CLK_MAX_HZ = 60_000_000;
  localparam int WIN_CYCLES        = 32;
  localparam int POR_EXT_CYCLES    = 2 ** 21;
  localparam int TMR_W             = 22;
  localparam int DIV_W             = 7;
  localparam int PRESCALE_BIT      = 6;

  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_STAT_OFS = 8'h04;
  localparam logic [7:0] REG_FDIV_OFS = 8'h08;

  localparam int CTRL_STOP_DIS_BIT = 0;
  localparam int CTRL_WAIT_DIS_BIT = 1;
  localparam int CTRL_LOCK_BIT     = 2;
  localparam int CTRL_SWRST_BIT    = 3;

  localparam logic             CTRL_RST  = 1'b0;
  localparam logic [DIV_W-1:0] FDIV_RST  = 7'h00;
  localparam logic [3:0]       CAUSE_RST = 4'h8;
  localparam logic [1:0]       HTRANS_NONSEQ = 2'h2;
  // Arbitrary default pattern of the security bytes that means secured
  localparam logic [15:0]      SEC_PATTERN_DEF = 16'hA5C3;

  typedef struct packed {
    logic             ext_rst_n;
    logic             por;
    logic             nonclk_irq;
    logic             can_act;
    logic             jtag_sel;
    logic             jtag_run_idle;
    logic             jtag_div_valid;
    logic [DIV_W-1:0] lockout_clock_divider;
  } rps_pins_t;

  localparam rps_pins_t PINS_IDLE = 14'h2000;

  typedef enum logic [2:0] {SQ_HOLD, SQ_POR, SQ_CLK, SQ_PERI, SQ_CORE, SQ_RUN} rps_seq_t;
  typedef enum logic [1:0] {PM_RUN, PM_WAIT, PM_STOP} rps_pm_t;
  typedef enum logic [1:0] {LR_IDLE, LR_ARMED, LR_ERASE, LR_DONE} rps_lr_t;

endpackage : rps_pkg

// ### rtl/rps_sync.sv
// Two-flop synchroniser for signals from outside the clock domain
`timescale 1ns/1ns
module rps_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             clk_en_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] stable_ff;

  // First stage is read only by the second
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_ff   <= RST_VAL;
      stable_ff <= RST_VAL;
    end else if (clk_en_in) begin
      meta_ff   <= d_in;
      stable_ff <= meta_ff;
    end
  end

  assign q_out = stable_ff;

endmodule : rps_sync

// ### rtl/rps_timer.sv
// Loadable down counter timing the reset release windows
`timescale 1ns/1ns
module rps_timer #(
  parameter int W = 22
) (
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         clk_en_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] load_val_in,
  output logic      [W-1:0] cnt_out,
  output logic              done_out
);
  logic [W-1:0] cnt_ff;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_ff <= '0;
    end else if (clk_en_in) begin
      if (load_in) begin
        cnt_ff <= load_val_in;
      end else if (cnt_ff != '0) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  assign cnt_out  = cnt_ff;
  assign done_out = (cnt_ff == '0);

endmodule : rps_timer

// ### rtl/rps_top.sv
// Reset sequencer, power modes, boot security and lockout recovery with an AHB-Lite slave
//
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
module rps_top #(
  parameter int          POR_EXT_CYC = rps_pkg::POR_EXT_CYCLES,
  parameter logic [15:0] SEC_PATTERN = rps_pkg::SEC_PATTERN_DEF
) (
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              clk_en_in,
  input  wire logic              hsel_in,
  input  wire logic [31:0]       haddr_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hwrite_in,
  input  wire logic [2:0]        hsize_in,
  input  wire logic [31:0]       hwdata_in,
  input  wire logic              hready_in,
  output logic      [31:0]       hrdata_out,
  output logic                   hreadyout_out,
  output logic                   hresp_out,
  input  wire rps_pkg::rps_pins_t pins_in,
  input  wire logic              operating_watchdog_rst_in,
  input  wire logic              stop_req_in,
  input  wire logic              wait_req_in,
  input  wire logic              periph_irq_in,
  input  wire logic [15:0]       sec_bytes_in,
  input  wire logic              backdoor_key_enable_in,
  input  wire logic              key_match_in,
  input  wire logic              erase_done_in,
  output logic                   core_clk_en_out,
  output logic                   mem_clk_en_out,
  output logic                   peripheral_bus_clk_en_out,
  output logic                   integ_clk_en_out,
  output logic                   wdog_clk_en_out,
  output logic                   periph_rst_out,
  output logic                   core_rst_out,
  output logic                   secure_out,
  output logic                   debug_disable_out,
  output logic                   mem_read_disable_out,
  output logic                   tap_enable_out,
  output logic                   backdoor_grant_out,
  output logic                   prescale_by_eight_select_out,
  output logic      [5:0]        divide_ratio_out,
  output logic                   mass_erase_out
);
  import rps_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  rps_pins_t pins_s;

  rps_sync #(
    .WIDTH   ($bits(rps_pins_t)),
    .RST_VAL (PINS_IDLE)
  ) u_pin_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .d_in       (pins_in),
    .q_out      (pins_s)
  );

  logic sw_rst_ff;
  // Async sources only reach the sequencer through the synchroniser
  wire ext_rst  = !pins_s.ext_rst_n; // RULE10
  wire por_rst  = pins_s.por;        // RULE10
  wire rst_any  = ext_rst || por_rst || operating_watchdog_rst_in || sw_rst_ff; // RULE7
  wire [3:0] rst_src = {por_rst, ext_rst, operating_watchdog_rst_in, sw_rst_ff};

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: one wait state on every transfer
  logic        pend_ff;
  logic        wr_ff;
  logic [7:0]  addr_ff;
  logic [31:0] hrdata_ff;
  logic        hreadyout_ff;
  logic        hresp_ff;
  logic        stop_dis_ff;
  logic        wait_dis_ff;
  logic        lock_ff;
  logic [DIV_W-1:0] fdiv_ff;
  logic [3:0]  cause_ff;
  logic        secure_ff;
  rps_seq_t    seq_ff;
  rps_pm_t     pm_ff;
  rps_lr_t     lr_ff;

  wire bus_accept = hsel_in && htrans_in[1] && hready_in;
  wire wr_go      = pend_ff && wr_ff;
  wire wr_ctrl    = wr_go && (addr_ff == REG_CTRL_OFS);
  wire wr_fdiv    = wr_go && (addr_ff == REG_FDIV_OFS);

  wire [31:0] rd_ctrl = {28'h000_0000, 1'b0, lock_ff, wait_dis_ff, stop_dis_ff};
  wire [31:0] rd_stat = {20'h0_0000, cause_ff, 2'(lr_ff), secure_ff, 3'(seq_ff), 2'(pm_ff)};
  wire [31:0] rd_fdiv = {25'h000_0000, fdiv_ff};
  wire [31:0] rd_data = (addr_ff == REG_CTRL_OFS) ? rd_ctrl :
                        (addr_ff == REG_STAT_OFS) ? rd_stat :
                        (addr_ff == REG_FDIV_OFS) ? rd_fdiv : 32'h0000_0000;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pend_ff      <= 1'b0;
      wr_ff        <= 1'b0;
      addr_ff      <= 8'h00;
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else if (clk_en_in) begin
      if (bus_accept) begin
        pend_ff      <= 1'b1;
        wr_ff        <= hwrite_in;
        addr_ff      <= haddr_in[7:0];
        hreadyout_ff <= 1'b0;
      end else if (pend_ff) begin
        pend_ff      <= 1'b0;
        hreadyout_ff <= 1'b1;
        hrdata_ff    <= wr_ff ? 32'h0000_0000 : rd_data;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control and flash divide registers
  // Lock freezes both disable bits; only a reset of any kind frees them
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      stop_dis_ff <= CTRL_RST;
      wait_dis_ff <= CTRL_RST;
      lock_ff     <= CTRL_RST;
      sw_rst_ff   <= 1'b0;
      fdiv_ff     <= FDIV_RST;
    end else if (clk_en_in) begin
      sw_rst_ff <= wr_ctrl && hwdata_in[CTRL_SWRST_BIT]; // RULE7
      if (seq_ff == SQ_HOLD) begin
        stop_dis_ff <= CTRL_RST; // RULE6
        wait_dis_ff <= CTRL_RST;
        lock_ff     <= CTRL_RST;
      end else if (wr_ctrl && !lock_ff) begin
        stop_dis_ff <= hwdata_in[CTRL_STOP_DIS_BIT]; // RULE6
        wait_dis_ff <= hwdata_in[CTRL_WAIT_DIS_BIT];
        lock_ff     <= hwdata_in[CTRL_LOCK_BIT];
      end
      if (wr_fdiv) begin
        fdiv_ff <= hwdata_in[DIV_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset release sequencer
  rps_seq_t         nxt_seq;
  logic             por_pend_ff;
  logic             tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic [TMR_W-1:0] tmr_cnt;
  logic             tmr_done;

  rps_timer #(
    .W (TMR_W)
  ) u_win_timer (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .clk_en_in   (clk_en_in),
    .load_in     (tmr_load),
    .load_val_in (tmr_val),
    .cnt_out     (tmr_cnt),
    .done_out    (tmr_done)
  );

  always_comb begin
    nxt_seq  = seq_ff;
    tmr_load = 1'b0;
    tmr_val  = TMR_W'(WIN_CYCLES - 1);
    if (rst_any) begin
      nxt_seq = SQ_HOLD;
    end else begin
      case (seq_ff)
        SQ_HOLD: begin
          tmr_load = 1'b1;
          if (por_pend_ff) begin
            nxt_seq = SQ_POR;
            tmr_val = TMR_W'(POR_EXT_CYC - 1); // RULE8
          end else begin
            nxt_seq = SQ_CLK;
          end
        end
        SQ_POR: begin
          if (tmr_done) begin
            nxt_seq  = SQ_CLK;
            tmr_load = 1'b1;
          end
        end
        SQ_CLK: begin
          if (tmr_done) begin
            nxt_seq  = SQ_PERI; // RULE9
            tmr_load = 1'b1;
          end
        end
        SQ_PERI: begin
          if (tmr_done) begin
            nxt_seq  = SQ_CORE; // RULE9
            tmr_load = 1'b1;
          end
        end
        SQ_CORE: begin
          if (tmr_done) begin
            nxt_seq = SQ_RUN; // RULE9
          end
        end
        SQ_RUN: begin
          nxt_seq = SQ_RUN;
        end
        default: begin
          nxt_seq = SQ_HOLD;
        end
      endcase
    end
  end

  // A new power-on event wins over the clear as the extension starts
  wire por_taken = (seq_ff == SQ_HOLD) && !rst_any;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      seq_ff      <= SQ_HOLD;
      por_pend_ff <= 1'b1;
      cause_ff    <= CAUSE_RST;
    end else if (clk_en_in) begin
      seq_ff      <= nxt_seq; // RULE10
      por_pend_ff <= por_rst || (por_pend_ff && !por_taken); // RULE8
      if (rst_any) begin
        cause_ff <= (seq_ff == SQ_HOLD) ? (cause_ff | rst_src) : rst_src;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power modes
  rps_pm_t nxt_pm;
  // CAN wake is raw bus activity, so the waking frame itself is not received
  wire wake_stop = pins_s.can_act || pins_s.nonclk_irq;

  always_comb begin
    nxt_pm = pm_ff;
    if (nxt_seq != SQ_RUN || seq_ff != SQ_RUN) begin
      nxt_pm = PM_RUN;
    end else begin
      case (pm_ff)
        PM_RUN: begin
          if (stop_req_in && !stop_dis_ff) begin
            nxt_pm = PM_STOP; // RULE6
          end else if (wait_req_in && !wait_dis_ff) begin
            nxt_pm = PM_WAIT; // RULE6
          end
        end
        PM_WAIT: begin
          if (periph_irq_in) begin
            nxt_pm = PM_RUN; // RULE2
          end
        end
        PM_STOP: begin
          if (wake_stop) begin
            nxt_pm = PM_RUN; // RULE3
          end
        end
        default: begin
          nxt_pm = PM_RUN;
        end
      endcase
    end
  end

  wire integ_on = !(nxt_seq inside {SQ_HOLD, SQ_POR});
  wire core_on  = (nxt_seq inside {SQ_CORE, SQ_RUN}) && (nxt_pm == PM_RUN);

  logic core_clk_ff;
  logic periph_clk_ff;
  logic integ_clk_ff;
  logic periph_rst_ff;
  logic core_rst_ff;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pm_ff         <= PM_RUN;
      core_clk_ff   <= 1'b0;
      periph_clk_ff <= 1'b0;
      integ_clk_ff  <= 1'b0;
      periph_rst_ff <= 1'b1;
      core_rst_ff   <= 1'b1;
    end else if (clk_en_in) begin
      pm_ff         <= nxt_pm;
      core_clk_ff   <= core_on; // RULE1
      periph_clk_ff <= integ_on && (nxt_pm != PM_STOP); // RULE4
      integ_clk_ff  <= integ_on; // RULE24
      periph_rst_ff <= nxt_seq inside {SQ_HOLD, SQ_POR, SQ_CLK}; // RULE9
      core_rst_ff   <= nxt_seq != SQ_RUN; // RULE9
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Boot security and backdoor
  wire sec_match = (sec_bytes_in == SEC_PATTERN); // RULE11
  wire sec_latch = (seq_ff == SQ_CLK) && tmr_done && !rst_any;
  logic grant_ff;

  // Held secured from block reset until first sampled; later resets keep the previous decision until resampled
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      secure_ff <= 1'b1;
      grant_ff  <= 1'b0;
    end else if (clk_en_in) begin
      if (sec_latch) begin
        secure_ff <= sec_match; // RULE13
      end
      grant_ff <= secure_ff && backdoor_key_enable_in && key_match_in; // RULE22
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lockout recovery
  rps_lr_t          nxt_lr;
  logic [DIV_W-1:0] jdiv_ff;
  logic [DIV_W-1:0] div_eff_ff;
  logic             erase_ff;

  always_comb begin
    nxt_lr = lr_ff;
    case (lr_ff)
      LR_IDLE: begin
        if (pins_s.jtag_sel && pins_s.jtag_div_valid) begin
          nxt_lr = LR_ARMED; // RULE16
        end
      end
      LR_ARMED: begin
        if (!pins_s.jtag_sel) begin
          nxt_lr = LR_IDLE;
        end else if (pins_s.jtag_run_idle) begin
          nxt_lr = LR_ERASE; // RULE19
        end
      end
      LR_ERASE: begin
        if (erase_done_in) begin
          nxt_lr = LR_DONE;
        end else if (!pins_s.jtag_run_idle) begin
          nxt_lr = LR_ARMED; // RULE19
        end
      end
      LR_DONE: begin
        nxt_lr = LR_DONE;
      end
      default: begin
        nxt_lr = LR_IDLE;
      end
    endcase
    if (seq_ff == SQ_HOLD) begin
      nxt_lr = LR_IDLE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      lr_ff      <= LR_IDLE;
      jdiv_ff    <= FDIV_RST;
      div_eff_ff <= FDIV_RST;
      erase_ff   <= 1'b0;
    end else if (clk_en_in) begin
      lr_ff <= nxt_lr;
      if (lr_ff == LR_IDLE && nxt_lr == LR_ARMED) begin
        jdiv_ff <= pins_s.lockout_clock_divider; // RULE16
      end
      div_eff_ff <= (lr_ff != LR_IDLE) ? jdiv_ff : fdiv_ff; // RULE17
      erase_ff   <= nxt_lr == LR_ERASE; // RULE20
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  logic tap_en_ff;

  assign hrdata_out                   = hrdata_ff;
  assign hreadyout_out                = hreadyout_ff;
  assign hresp_out                    = hresp_ff;
  assign core_clk_en_out              = core_clk_ff;
  assign mem_clk_en_out               = core_clk_ff;
  assign peripheral_bus_clk_en_out    = periph_clk_ff;
  assign integ_clk_en_out             = integ_clk_ff;
  assign wdog_clk_en_out              = integ_clk_ff;
  assign periph_rst_out               = periph_rst_ff;
  assign core_rst_out                 = core_rst_ff;
  assign secure_out                   = secure_ff;
  assign debug_disable_out            = secure_ff; // RULE12
  assign mem_read_disable_out         = secure_ff; // RULE15
  assign tap_enable_out               = tap_en_ff; // RULE14
  assign backdoor_grant_out           = grant_ff;
  assign prescale_by_eight_select_out = div_eff_ff[PRESCALE_BIT]; // RULE17
  assign divide_ratio_out             = div_eff_ff[5:0];
  assign mass_erase_out               = erase_ff;

  // TAP stays off only while the block itself is held in reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tap_en_ff <= 1'b0;
    end else if (clk_en_in) begin
      tap_en_ff <= 1'b1; // RULE14
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in || !clk_en_in);

  sequence s_peri_start;
    (seq_ff == SQ_PERI) && (tmr_cnt == 22'(WIN_CYCLES - 1)) && periph_rst_out == 1'b0;
  endsequence

  sequence s_held_in_reset;
    (seq_ff == SQ_HOLD) && core_rst_out && periph_rst_out;
  endsequence

  a_run_clocks_on: assert property ((pm_ff == PM_RUN) && (seq_ff == SQ_RUN) |-> // RULE1
    core_clk_en_out && peripheral_bus_clk_en_out) else $error("Run clocks off");
  a_wait_core_gated: assert property ((pm_ff == PM_WAIT) |-> // RULE2
    !core_clk_en_out && !mem_clk_en_out && peripheral_bus_clk_en_out) else $error("Wait gating wrong");
  a_wait_irq_wake: assert property ((pm_ff == PM_WAIT) && periph_irq_in && !rst_any |=> // RULE2
    (pm_ff == PM_RUN) && core_clk_en_out) else $error("Wait not woken");
  a_stop_no_exit: assert property ((pm_ff == PM_STOP) && !wake_stop && !rst_any |=> // RULE3
    (pm_ff == PM_STOP) && integ_clk_en_out && !peripheral_bus_clk_en_out) else $error("Stop left");
  a_stop_disabled: assert property ((pm_ff == PM_RUN) && stop_dis_ff |=> // RULE6
    pm_ff != PM_STOP) else $error("Stop entered while disabled");
  a_lock_holds: assert property (lock_ff && (seq_ff != SQ_HOLD) |=> // RULE6
    $stable(stop_dis_ff) && $stable(wait_dis_ff)) else $error("Locked disable changed");
  a_reset_entry: assert property (rst_any |=> s_held_in_reset ##1 core_rst_out) // RULE7
    else $error("Reset not held");
  a_por_extend: assert property ((seq_ff == SQ_POR) && ($past(seq_ff) == SQ_HOLD) |-> // RULE8
    tmr_cnt == 22'(POR_EXT_CYC - 1)) else $error("Power-on extension wrong");
  a_window_step: assert property ((seq_ff == SQ_CLK) && tmr_done && !rst_any |=> s_peri_start) // RULE9
    else $error("Window sequence wrong");
  a_core_release: assert property ((seq_ff == SQ_CORE) && tmr_done && !rst_any |=> !core_rst_out) // RULE9
    else $error("Core not released");
  a_secure_sample: assert property (sec_latch |=> (secure_out == $past(sec_match)) && // RULE15
    (mem_read_disable_out == $past(sec_match))) else $error("Security sample wrong");
  a_recovery_div: assert property ((lr_ff != LR_IDLE) |=> // RULE17
    ({prescale_by_eight_select_out, divide_ratio_out} == $past(jdiv_ff))) else $error("Divider not replaced");
  a_erase_start: assert property ((lr_ff == LR_ARMED) && pins_s.jtag_sel && pins_s.jtag_run_idle && // RULE19
    (seq_ff != SQ_HOLD) |=> mass_erase_out) else $error("Erase not started");
  a_backdoor_key: assert property (backdoor_grant_out |-> $past(backdoor_key_enable_in)) // RULE22
    else $error("Backdoor without key enable");
  a_bus_wait: assert property (bus_accept |=> !hreadyout_out ##1 hreadyout_out && !hresp_out)
    else $error("Bus answer timing wrong");

endmodule : rps_top

// ### tb/rps_host_model.sv
// Far-side model: JTAG lockout host, wake source and flash erase status
`timescale 1ns/1ns
module rps_host_model (
  input  wire logic          clk_in,
  input  wire logic          go_in,
  input  wire logic          wake_in,
  input  wire logic [6:0]    div_in,
  output rps_pkg::rps_pins_t pins_out,
  output logic               erase_done_out
);
  import rps_pkg::*;
  logic [5:0] st_ff = '0;
  wire        sel = go_in && st_ff >= 6'h01 && st_ff < 6'h28;
  wire        vld = sel && st_ff >= 6'h03;
  //////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (!go_in) st_ff <= '0;
    else if (st_ff != 6'h3F) st_ff <= st_ff + 6'h01;
  end
  always_comb begin
    pins_out = PINS_IDLE;
    pins_out.nonclk_irq = wake_in;
    pins_out.jtag_sel = sel;
    pins_out.jtag_div_valid = vld;
    // Released data line shows the inverse so a stale value never matches
    pins_out.lockout_clock_divider = vld ? div_in : ~div_in;
    pins_out.jtag_run_idle = sel && st_ff >= 6'h06;
    pins_out.ext_rst_n = !(st_ff >= 6'h2C && st_ff < 6'h32);
    erase_done_out = st_ff >= 6'h1E && st_ff < 6'h28;
  end
endmodule : rps_host_model

// ### tb/rps_tb_top.sv
// Self-checking bench for the reset, power and security controller
`timescale 1ns/1ns
module rps_tb_top;
  import rps_pkg::*;
  logic clk_in = 0, sys_rst_in = 1, hsel = 0, hw = 0, wdog = 0, stp = 0, wt = 0, irq = 0, cen = 1;
  logic kena = 0, kmat = 0, go = 0, wake = 0, ed, hrdy, hresp, cc, mc, pc, ic, wc, prst, crst;
  logic sec_o, dbg, mrd, tap, bdg, pre, mers;
  logic [5:0] rat;
  logic [1:0] htr = 0;
  logic [31:0] ha = 0, hwd = 0, hrd, rd;
  logic [15:0] sec = SEC_PATTERN_DEF;
  rps_pins_t pins;
  int mismatches = 0, compares = 0, cyc = 0, nb;
  //////////////////////////////////////////////////////////////
  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 4000) begin
      mismatches++;
      results();
    end
  end
  rps_top #(.POR_EXT_CYC(8)) rps_top_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(cen),
    .hsel_in(hsel), .haddr_in(ha), .htrans_in(htr), .hwrite_in(hw), .hsize_in(3'h2), .hwdata_in(hwd),
    .hready_in(hrdy), .hrdata_out(hrd), .hreadyout_out(hrdy), .hresp_out(hresp), .pins_in(pins),
    .operating_watchdog_rst_in(wdog), .stop_req_in(stp), .wait_req_in(wt), .periph_irq_in(irq),
    .sec_bytes_in(sec), .backdoor_key_enable_in(kena), .key_match_in(kmat), .erase_done_in(ed),
    .core_clk_en_out(cc), .mem_clk_en_out(mc), .peripheral_bus_clk_en_out(pc), .integ_clk_en_out(ic),
    .wdog_clk_en_out(wc), .periph_rst_out(prst), .core_rst_out(crst), .secure_out(sec_o),
    .debug_disable_out(dbg), .mem_read_disable_out(mrd), .tap_enable_out(tap), .backdoor_grant_out(bdg),
    .prescale_by_eight_select_out(pre), .divide_ratio_out(rat), .mass_erase_out(mers));
  // Divider chosen for 25 MHz flash input: /8 then /18 gives about 174 kHz
  rps_host_model rps_host_model_inst (.clk_in(clk_in), .go_in(go), .wake_in(wake), .div_in(7'h51),
    .pins_out(pins), .erase_done_out(ed));
  //////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel <= 1;
    htr <= HTRANS_NONSEQ;
    ha <= {24'h00_0000, a};
    hw <= w;
    do @(posedge clk_in); while (hrdy !== 1'b1);
    hsel <= 0;
    htr <= 2'h0;
    hwd <= d;
    do @(posedge clk_in); while (hrdy !== 1'b1);
    rd = hrd;
  endtask : bus
  task automatic st(int n);
    repeat (n) @(posedge clk_in);
  endtask : st
  task automatic boot;
    nb = 0;
    while (crst !== 1'b0) begin
      @(posedge clk_in);
      nb++;
    end
  endtask : boot
  task automatic reboot;
    while (crst !== 1'b1) @(posedge clk_in);
    boot();
  endtask : reboot
  task automatic t_boot;
    boot();
    chk("boot_len", nb >= 104, 1);
    chk("clocks", {cc, mc, pc, prst}, 4'he);
    chk("secure", {sec_o, dbg, mrd}, 3'h7);
    chk("tap", tap, 1);
    bus(0, REG_STAT_OFS, 0);
    chk("seq", rd[4:2], 5);
  endtask : t_boot
  task automatic t_power;
    @(posedge clk_in);
    wt <= 1;
    st(2);
    chk("wait_clk", {cc, pc}, 2'h1);
    @(posedge clk_in);
    irq <= 1;
    wt <= 0;
    st(2);
    chk("wait_wake", cc, 1);
    irq <= 0;
    stp <= 1;
    st(2);
    chk("stop_clk", {cc, pc, ic, wc}, 4'h3);
    stp <= 0;
    st(6);
    chk("stop_hold", cc, 0);
    wake <= 1;
    st(4);
    chk("stop_wake", {cc, pc}, 2'h3);
    wake <= 0;
  endtask : t_power
  task automatic t_lock;
    bus(1, REG_CTRL_OFS, 32'h0000_0007);
    @(posedge clk_in);
    wt <= 1;
    stp <= 1;
    st(3);
    chk("wait_dis", cc, 1);
    wt <= 0;
    stp <= 0;
    bus(1, REG_CTRL_OFS, 0);
    bus(0, REG_CTRL_OFS, 0);
    chk("lock", rd[2:0], 3'h7);
    bus(1, REG_CTRL_OFS, 32'h0000_0008);
    reboot();
    bus(0, REG_CTRL_OFS, 0);
    chk("unlock", rd[2:0], 0);
    @(posedge clk_in);
    wdog <= 1;
    @(posedge clk_in);
    wdog <= 0;
    reboot();
    chk("wdog_rst", nb > 96, 1);
  endtask : t_lock
  task automatic t_reg;
    bus(1, REG_FDIV_OFS, 32'h0000_0013);
    bus(0, REG_FDIV_OFS, 0);
    chk("fdiv", rd, 32'h0000_0013);
    chk("fdiv_out", {pre, rat}, 7'h13);
    bus(0, 8'h0C, 0);
    chk("unmapped", rd, 0);
    chk("hresp", hresp, 0);
  endtask : t_reg
  task automatic t_key;
    kena <= 1;
    kmat <= 1;
    st(2);
    chk("key_on", bdg, 1);
    cen <= 0;
    kmat <= 0;
    st(3);
    chk("key_frozen", bdg, 1);
    cen <= 1;
    kmat <= 1;
    kena <= 0;
    st(2);
    chk("key_off", bdg, 0);
  endtask : t_key
  task automatic t_rec;
    go <= 1;
    while (mers !== 1'b1) @(posedge clk_in);
    st(1);
    chk("jtag_div", {pre, rat}, 7'h51);
    while (mers !== 1'b0) @(posedge clk_in);
    bus(0, REG_STAT_OFS, 0);
    chk("rec_done", rd[7:6], 3);
    sec <= 16'h0000;
    reboot();
    chk("unsecured", {sec_o, dbg, mrd, tap}, 4'h1);
    go <= 0;
  endtask : t_rec
  task automatic results;
    $display("Checks %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  initial begin
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 0;
    t_boot();
    t_power();
    t_reg();
    t_key();
    t_lock();
    @(posedge clk_in);
    t_rec();
    results();
  end
endmodule : rps_tb_top
